/* File: rtl/dio_pkg.sv */
// constants and types of the direct and i/o command responder
package dio_pkg;
   // command codes on the i/o command pins
   typedef enum logic [2:0] {
      DIO_CMD_START = 3'h0,
      DIO_CMD_TEST  = 3'h1,
      DIO_CMD_TDEV  = 3'h2,
      DIO_CMD_HALT  = 3'h3,
      DIO_CMD_ACK   = 3'h4
   } dio_cmd_type;

   localparam int          DIO_IO_ADDR_W       = 11;
   localparam int          DIO_DIRECT_ADDR_W   = 16;
   localparam int          DIO_MODE_W          = 4;
   localparam logic [3:0]  DIO_MODE_INTR       = 4'h1;
   localparam int unsigned DIO_EXIT_DELAY_CLKS = 4;

   // software register offsets
   localparam logic [4:0] DIO_REG_CTRL   = 5'h00;
   localparam logic [4:0] DIO_REG_IOADDR = 5'h04;
   localparam logic [4:0] DIO_REG_DADDR  = 5'h08;
   localparam logic [4:0] DIO_REG_CODES  = 5'h0C;
   localparam logic [4:0] DIO_REG_STATUS = 5'h10;
   localparam logic [4:0] DIO_REG_WDATA  = 5'h14;
   localparam logic [4:0] DIO_REG_CDW    = 5'h18;

   // control register fields
   localparam int DIO_CTRL_ACTION   = 0;
   localparam int DIO_CTRL_CTL_BUSY = 1;
   localparam int DIO_CTRL_IOP_BUSY = 2;
   localparam int DIO_CTRL_REFUSE   = 3;
   localparam int DIO_CTRL_DEVCOND  = 4;
   localparam int DIO_CTRL_INTPEND  = 5;
   localparam int DIO_CTRL_DONE     = 6;
   localparam int DIO_CTRL_W        = 6;

   // status register fields
   localparam int DIO_ST_INTPEND = 0;
   localparam int DIO_ST_CTL_BUSY = 1;
   localparam int DIO_ST_XCHG    = 2;
   localparam int DIO_ST_WAITACT = 3;
   localparam int DIO_ST_LASTCMD = 4;

   localparam logic [DIO_CTRL_W-1:0]        DIO_CTRL_RESET   = 6'h00;
   localparam logic [DIO_IO_ADDR_W-1:0]     DIO_IOADDR_RESET = 11'h000;
   localparam logic [DIO_DIRECT_ADDR_W-1:0] DIO_DADDR_RESET  = 16'h0000;
   localparam logic [3:0]                   DIO_CODES_RESET  = 4'h0;
endpackage : dio_pkg

/* File: rtl/dio_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dio_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic         clk_en,
   // data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (clk_en) begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : dio_sync
`default_nettype wire

/* File: rtl/dio_responder.sv */
// far-side element answering direct writes and i/o commands
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dio_responder #(
   parameter int unsigned EXIT_DELAY = dio_pkg::DIO_EXIT_DELAY_CLKS
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   // direct exchange pins from the cpu
   input  wire logic        function_strobe_line,
   input  wire logic [15:0] direct_addr,
   input  wire logic [31:0] direct_data,
   input  wire logic [3:0]  direct_mode,
   output logic             function_strobe_ack,
   output logic             return_code_line_a,
   output logic             return_code_line_b,
   output logic             direct_exchange_exit,
   // i/o command pins from the cpu
   input  wire logic        io_cmd_strobe,
   input  wire logic [2:0]  io_cmd_code,
   input  wire logic [31:0] io_eff_addr,
   input  wire logic [3:0]  io_r_field,
   input  wire logic [31:0] io_gen_reg0,
   output logic             io_resp_valid,
   output logic             cond_code_bit_one,
   output logic             cond_code_bit_two,
   output logic [1:0]       io_status_count,
   output logic [10:0]      io_ret_addr,
   // software port
   input  wire logic [4:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic [31:0]      sw_rdata
);
   localparam int SYNC_W = 1 + 16 + 32 + 4 + 1 + 3 + 32 + 4 + 32;

   typedef enum logic [2:0] {
      DX_IDLE, DX_COUNT, DX_ACTION, DX_EXIT
   } dio_dx_state_type;

   // synchronised pins
   logic [SYNC_W-1:0] pins_s;
   logic              fs_s;
   logic [15:0]       daddr_s;
   logic [31:0]       ddata_s;
   logic [3:0]        dmode_s;
   logic              cs_s;
   logic [2:0]        ccode_s;
   logic [31:0]       eaddr_s;
   logic [3:0]        rfld_s;
   logic [31:0]       reg0_s;

   dio_sync #(.W(SYNC_W)) i_dio_sync (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .async_in ({function_strobe_line, direct_addr, direct_data, direct_mode,
                  io_cmd_strobe, io_cmd_code, io_eff_addr, io_r_field, io_gen_reg0}),
      .sync_out (pins_s)
   );

   assign {fs_s, daddr_s, ddata_s, dmode_s, cs_s, ccode_s, eaddr_s, rfld_s, reg0_s} = pins_s;

   // software registers
   logic [dio_pkg::DIO_CTRL_W-1:0]        ctrl_q;
   logic [dio_pkg::DIO_IO_ADDR_W-1:0]     ioaddr_q;
   logic [dio_pkg::DIO_DIRECT_ADDR_W-1:0] daddr_q;
   logic [3:0]                            codes_q;
   logic [31:0]                           wdata_q;
   logic [31:0]                           cdw_q;
   logic                                  intpend_q;
   logic                                  ctl_busy_q;
   logic                                  done_q;
   logic [2:0]                            lastcmd_q;
   logic [31:0]                           sw_rdata_q;

   // exchange state
   dio_dx_state_type                      dx_q;
   logic [7:0]                            cnt_q;
   logic                                  fsa_q;
   logic                                  code_a_q;
   logic                                  code_b_q;
   logic                                  exit_q;

   // command state
   logic                                  cs_d1_q;
   logic                                  resp_q;
   logic                                  cc1_q;
   logic                                  cc2_q;
   logic [1:0]                            scount_q;
   logic [10:0]                           raddr_q;

   // decode
   logic        fs_rise;
   logic        dx_match;
   logic        intr_mode;
   logic        cs_rise;
   logic [10:0] cmd_addr;
   logic        cmd_hit;
   logic        is_start;
   logic        is_halt;
   logic        is_test;
   logic        is_tdev;
   logic        is_ack;
   logic [1:0]  start_cc;
   logic [1:0]  halt_cc;
   logic [1:0]  test_cc;
   logic [1:0]  tdev_cc;
   logic [1:0]  ack_cc;
   logic [1:0]  cmd_cc;
   logic        start_ok;
   logic        halt_ok;
   logic        ack_ok;
   logic        wr_ctrl;
   logic        sw_set_int;
   logic        hw_clr_int;
   logic        cnt_done;
   logic [31:0] rd_mux;

   function automatic logic [1:0] status_words(input logic [3:0] r);
      // no status for r zero, one word for odd r, two for even
      if (r == 4'h0) begin
         return 2'h0;
      end
      return r[0] ? 2'h1 : 2'h2;
   endfunction : status_words

   assign fs_rise   = fs_s && (dx_q == DX_IDLE) && !fsa_q;
   assign intr_mode = (dmode_s == dio_pkg::DIO_MODE_INTR);
   // interrupt-mode writes go to the cpu interrupt system, not to us
   assign dx_match  = (daddr_s == daddr_q) && !intr_mode && (dmode_s != 4'h0);
   assign cnt_done  = (cnt_q == 8'(EXIT_DELAY - 1));

   assign cs_rise   = cs_s && !cs_d1_q;
   assign cmd_addr  = eaddr_s[dio_pkg::DIO_IO_ADDR_W-1:0];
   assign cmd_hit   = (cmd_addr == ioaddr_q);
   assign is_start  = (ccode_s == dio_pkg::DIO_CMD_START);
   assign is_halt   = (ccode_s == dio_pkg::DIO_CMD_HALT);
   assign is_test   = (ccode_s == dio_pkg::DIO_CMD_TEST);
   assign is_tdev   = (ccode_s == dio_pkg::DIO_CMD_TDEV);
   assign is_ack    = (ccode_s == dio_pkg::DIO_CMD_ACK);

   assign start_cc  = !cmd_hit ? 2'h3 :
                      ctrl_q[dio_pkg::DIO_CTRL_IOP_BUSY] ? 2'h2 :
                      (ctrl_q[dio_pkg::DIO_CTRL_REFUSE] || ctl_busy_q) ? 2'h1 : 2'h0;
   assign halt_cc   = !cmd_hit ? 2'h3 :
                      ctrl_q[dio_pkg::DIO_CTRL_CTL_BUSY] ? 2'h1 : 2'h0;
   assign test_cc   = !cmd_hit ? 2'h3 :
                      ctrl_q[dio_pkg::DIO_CTRL_IOP_BUSY] ? 2'h2 :
                      (ctrl_q[dio_pkg::DIO_CTRL_REFUSE] || ctl_busy_q) ? 2'h1 : 2'h0;
   assign tdev_cc   = !cmd_hit ? 2'h3 :
                      ctrl_q[dio_pkg::DIO_CTRL_IOP_BUSY] ? 2'h2 :
                      {1'b0, ctrl_q[dio_pkg::DIO_CTRL_DEVCOND]};
   // no pending interrupt: answer as unrecognised
   assign ack_cc    = intpend_q ? codes_q[3:2] : 2'h3;
   assign cmd_cc    = is_start ? start_cc :
                      is_halt  ? halt_cc :
                      is_test  ? test_cc :
                      is_tdev  ? tdev_cc :
                      is_ack   ? ack_cc : 2'h3;

   assign start_ok  = cs_rise && is_start && (start_cc == 2'h0);
   assign halt_ok   = cs_rise && is_halt && cmd_hit;
   assign ack_ok    = cs_rise && is_ack && intpend_q;
   assign hw_clr_int = halt_ok || ack_ok;
   assign wr_ctrl   = sw_wr && (sw_addr == dio_pkg::DIO_REG_CTRL);
   assign sw_set_int = wr_ctrl && sw_wdata[dio_pkg::DIO_CTRL_INTPEND];

   assign rd_mux = (sw_addr == dio_pkg::DIO_REG_CTRL)   ? {26'h0, ctrl_q} :
                   (sw_addr == dio_pkg::DIO_REG_IOADDR) ? {21'h0, ioaddr_q} :
                   (sw_addr == dio_pkg::DIO_REG_DADDR)  ? {16'h0, daddr_q} :
                   (sw_addr == dio_pkg::DIO_REG_CODES)  ? {28'h0, codes_q} :
                   (sw_addr == dio_pkg::DIO_REG_STATUS) ?
                      {25'h0, lastcmd_q, (dx_q == DX_ACTION), (dx_q != DX_IDLE), ctl_busy_q, intpend_q} :
                   (sw_addr == dio_pkg::DIO_REG_WDATA)  ? wdata_q :
                   (sw_addr == dio_pkg::DIO_REG_CDW)    ? cdw_q : 32'h0000_0000;

   // software side
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl_q     <= dio_pkg::DIO_CTRL_RESET;
         ioaddr_q   <= dio_pkg::DIO_IOADDR_RESET;
         daddr_q    <= dio_pkg::DIO_DADDR_RESET;
         codes_q    <= dio_pkg::DIO_CODES_RESET;
         done_q     <= 1'b0;
         sw_rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         done_q     <= wr_ctrl && sw_wdata[dio_pkg::DIO_CTRL_DONE];
         sw_rdata_q <= sw_rd ? rd_mux : 32'h0000_0000;
         if (wr_ctrl) begin
            ctrl_q <= sw_wdata[dio_pkg::DIO_CTRL_W-1:0];
         end
         if (sw_wr && (sw_addr == dio_pkg::DIO_REG_IOADDR)) begin
            ioaddr_q <= sw_wdata[10:0];
         end
         if (sw_wr && (sw_addr == dio_pkg::DIO_REG_DADDR)) begin
            daddr_q <= sw_wdata[15:0];
         end
         if (sw_wr && (sw_addr == dio_pkg::DIO_REG_CODES)) begin
            codes_q <= sw_wdata[3:0];
         end
      end
   end

   // interrupt pending and controller busy: set wins over clear (software set of intpend over hardware clear)
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         intpend_q  <= 1'b0;
         ctl_busy_q <= 1'b0;
      end else if (clk_en) begin
         if (sw_set_int) begin
            intpend_q <= 1'b1;
         end else if (hw_clr_int) begin
            intpend_q <= 1'b0;
         end
         if (start_ok) begin
            ctl_busy_q <= 1'b1;
         end else if (halt_ok) begin
            ctl_busy_q <= 1'b0;
         end
      end
   end

   // direct exchange sequencer
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dx_q     <= DX_IDLE;
         cnt_q    <= 8'h00;
         fsa_q    <= 1'b0;
         code_a_q <= 1'b0;
         code_b_q <= 1'b0;
         exit_q   <= 1'b0;
         wdata_q  <= 32'h0000_0000;
      end else if (clk_en) begin
         unique case (dx_q)
            DX_IDLE: begin
               if (!fs_s) begin
                  fsa_q  <= 1'b0;
                  exit_q <= 1'b0;
               end else if (fs_rise && dx_match) begin
                  fsa_q    <= 1'b1;
                  code_a_q <= codes_q[0];
                  code_b_q <= codes_q[1];
                  wdata_q  <= ddata_s;
                  cnt_q    <= 8'h00;
                  dx_q     <= DX_COUNT;
               end
            end
            DX_COUNT: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_done) begin
                  if (ctrl_q[dio_pkg::DIO_CTRL_ACTION]) begin
                     dx_q <= DX_ACTION;
                  end else begin
                     exit_q <= 1'b1;
                     dx_q   <= DX_EXIT;
                  end
               end
            end
            DX_ACTION: begin
               // cpu sits in its exchange phase until software ends the action
               if (done_q) begin
                  exit_q <= 1'b1;
                  dx_q   <= DX_EXIT;
               end
            end
            DX_EXIT: begin
               if (!fs_s) begin
                  fsa_q  <= 1'b0;
                  exit_q <= 1'b0;
                  dx_q   <= DX_IDLE;
               end
            end
         endcase
      end
   end

   // i/o command answers, held until the command strobe drops
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cs_d1_q   <= 1'b0;
         resp_q    <= 1'b0;
         cc1_q     <= 1'b0;
         cc2_q     <= 1'b0;
         scount_q  <= 2'h0;
         raddr_q   <= 11'h000;
         cdw_q     <= 32'h0000_0000;
         lastcmd_q <= 3'h0;
      end else if (clk_en) begin
         cs_d1_q <= cs_s;
         if (cs_rise) begin
            resp_q    <= 1'b1;
            lastcmd_q <= ccode_s;
            cc1_q     <= cmd_cc[1];
            cc2_q     <= cmd_cc[0];
            // halt, test and test-device carry no status words
            scount_q  <= (is_start && cmd_hit) ? status_words(rfld_s) : 2'h0;
            raddr_q   <= is_ack ? (intpend_q ? ioaddr_q : 11'h000) : cmd_addr;
            if (start_ok) begin
               cdw_q <= reg0_s;
            end
         end else if (!cs_s) begin
            resp_q <= 1'b0;
         end
      end
   end

   assign function_strobe_ack  = fsa_q;
   assign return_code_line_a   = code_a_q;
   assign return_code_line_b   = code_b_q;
   assign direct_exchange_exit = exit_q;
   assign io_resp_valid        = resp_q;
   assign cond_code_bit_one    = cc1_q;
   assign cond_code_bit_two    = cc2_q;
   assign io_status_count      = scount_q;
   assign io_ret_addr          = raddr_q;
   assign sw_rdata             = sw_rdata_q;
endmodule : dio_responder
`default_nettype wire

/* File: dv/dio_responder_chk.sv */
// concurrent checks on the responder pins and software port
`timescale 1ns/1ps
`default_nettype none
module dio_chk #(
   parameter int unsigned EXIT_DELAY = 4
) (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        clk_en,
   // direct exchange
   input wire logic [15:0] direct_addr,
   input wire logic [3:0]  direct_mode,
   input wire logic        function_strobe_ack,
   input wire logic        return_code_line_a,
   input wire logic        return_code_line_b,
   input wire logic        direct_exchange_exit,
   // i/o command
   input wire logic [2:0]  io_cmd_code,
   input wire logic [31:0] io_eff_addr,
   input wire logic [3:0]  io_r_field,
   input wire logic        io_resp_valid,
   input wire logic        cond_code_bit_one,
   input wire logic        cond_code_bit_two,
   input wire logic [1:0]  io_status_count,
   input wire logic [10:0] io_ret_addr,
   // software port
   input wire logic [4:0]  sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic        sw_wr
);
   logic        act_q;
   logic [15:0] daddr_q;
   logic [10:0] ioaddr_q;
   logic [1:0]  codes_q;
   logic [3:0]  ack_cnt_q;
   wire logic   ctrl_wr = sw_wr && sw_addr == dio_pkg::DIO_REG_CTRL;
   wire logic   done_wr = ctrl_wr && sw_wdata[dio_pkg::DIO_CTRL_DONE];
   wire logic   ack_go  = function_strobe_ack && !direct_exchange_exit;
   wire logic   cmd_st  = io_cmd_code == dio_pkg::DIO_CMD_START;
   wire logic   cmd_ack = io_cmd_code == dio_pkg::DIO_CMD_ACK;
   wire logic   cc_miss = cond_code_bit_one && cond_code_bit_two;

   // shadow of the settings that steer the pins; counter avoids a long repetition
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         {act_q, daddr_q, ioaddr_q, codes_q, ack_cnt_q} <= '0;
      end else if (clk_en) begin
         if (ctrl_wr) act_q <= sw_wdata[dio_pkg::DIO_CTRL_ACTION];
         if (sw_wr && sw_addr == dio_pkg::DIO_REG_DADDR) daddr_q <= sw_wdata[15:0];
         if (sw_wr && sw_addr == dio_pkg::DIO_REG_IOADDR) ioaddr_q <= sw_wdata[10:0];
         if (sw_wr && sw_addr == dio_pkg::DIO_REG_CODES) codes_q <= sw_wdata[1:0];
         ack_cnt_q <= function_strobe_ack ? ack_cnt_q + 4'(ack_go) : 4'h0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_done_exit;
      !direct_exchange_exit ##1 direct_exchange_exit;
   endsequence

   a_ack_on_match: assert property (
      $rose(function_strobe_ack) |-> $past(direct_addr) == daddr_q && $past(direct_mode) > 4'h1)
      else $error("strobe acknowledged for a wrong address or mode");
   a_codes_at_ack: assert property (
      function_strobe_ack |-> {return_code_line_b, return_code_line_a} == codes_q)
      else $error("code lines differ from the programmed codes");
   a_exit_delay: assert property (
      $rose(direct_exchange_exit) && !act_q |-> ack_cnt_q == 4'(EXIT_DELAY))
      else $error("exit rose at the wrong distance from acknowledge");
   a_exit_bounded: assert property (
      ack_go && !act_q |-> ack_cnt_q < 4'(EXIT_DELAY))
      else $error("exit late without an action");
   a_exit_after_done: assert property (
      done_wr && act_q && ack_go |=> s_done_exit)
      else $error("exit not two cycles after action done");
   a_drop_together: assert property (
      $fell(function_strobe_ack) |-> $fell(direct_exchange_exit))
      else $error("acknowledge and exit did not drop together");
   a_io_addr_miss: assert property (
      $rose(io_resp_valid) && !cmd_ack && io_eff_addr[10:0] != ioaddr_q |-> cc_miss)
      else $error("unrecognised i/o address not answered with both codes");
   a_start_count: assert property (
      $rose(io_resp_valid) && cmd_st && !cond_code_bit_one && !cond_code_bit_two
      |-> io_status_count == (io_r_field == 4'h0 ? 2'h0 : (io_r_field[0] ? 2'h1 : 2'h2)))
      else $error("start status word count wrong");
   a_ack_ret_addr: assert property (
      $rose(io_resp_valid) && cmd_ack |-> io_ret_addr == (cc_miss ? 11'h000 : ioaddr_q))
      else $error("acknowledge returned a wrong address");
   a_reset_idle: assert property (
      disable iff (1'b0) srst |=> !function_strobe_ack && !direct_exchange_exit && !io_resp_valid)
      else $error("outputs active after clear");
endmodule : dio_chk

bind dio_responder dio_chk #(.EXIT_DELAY(EXIT_DELAY)) i_dio_chk (.*);
`default_nettype wire

/* File: dv/dio_cpu_model.sv */
// cpu side model driving direct exchanges and i/o commands
`timescale 1ns/1ps
`default_nettype none
module dio_cpu_model (
   // clock
   input  wire logic        sys_clk,
   // direct exchange
   output logic             function_strobe_line,
   output logic [15:0]      direct_addr,
   output logic [31:0]      direct_data,
   output logic [3:0]       direct_mode,
   input  wire logic        function_strobe_ack,
   input  wire logic        return_code_line_a,
   input  wire logic        return_code_line_b,
   input  wire logic        direct_exchange_exit,
   // i/o command
   output logic             io_cmd_strobe,
   output logic [2:0]       io_cmd_code,
   output logic [31:0]      io_eff_addr,
   output logic [3:0]       io_r_field,
   output logic [31:0]      io_gen_reg0,
   input  wire logic        io_resp_valid,
   input  wire logic        cond_code_bit_one,
   input  wire logic        cond_code_bit_two,
   input  wire logic [1:0]  io_status_count,
   input  wire logic [10:0] io_ret_addr
);
   logic [7:0] macro_counter;
   logic       io_service_call_enable, memory_request_flag, data_request_hold;

   initial begin
      {function_strobe_line, io_cmd_strobe, direct_mode, io_cmd_code, io_r_field} = '0;
      {direct_addr, direct_data, io_eff_addr, io_gen_reg0} = '0;
      {macro_counter, io_service_call_enable, memory_request_flag, data_request_hold} = '0;
   end

   task automatic wd(input logic [15:0] a, input logic [31:0] d, input logic [3:0] m,
                     output logic ok, output logic [1:0] codes);
      int n;
      ok = 1'b0;
      @(posedge sys_clk);
      macro_counter <= 8'hFF;
      function_strobe_line <= 1'b1;
      direct_addr <= a;
      direct_data <= d;
      direct_mode <= m;
      io_service_call_enable <= m != 4'h1;
      for (n = 0; n < 12 && !ok; n++) begin
         @(posedge sys_clk);
         ok = function_strobe_ack === 1'b1;
      end
      codes = {return_code_line_b, return_code_line_a};
      for (n = 0; n < 80 && ok && direct_exchange_exit !== 1'b1; n++)
         @(posedge sys_clk);
      ok = ok && direct_exchange_exit === 1'b1;
      // released lines show the inverse so stale values cannot pass
      function_strobe_line <= 1'b0;
      direct_addr <= ~a;
      direct_data <= ~d;
      @(posedge sys_clk);
      memory_request_flag <= 1'b1;
      data_request_hold <= 1'b1;
      @(posedge sys_clk);
      {memory_request_flag, data_request_hold, io_service_call_enable} <= 3'b000;
      for (n = 0; n < 10 && function_strobe_ack !== 1'b0; n++)
         @(posedge sys_clk);
   endtask : wd

   // resp is {answered, cc1, cc2, count, address}
   task automatic io(input logic slave, input logic [2:0] c, input logic [31:0] ea, input logic [3:0] r,
                     input logic [31:0] g0, output logic [15:0] resp);
      int n;
      resp = '0;
      if (slave) return;
      @(posedge sys_clk);
      io_cmd_strobe <= 1'b1;
      io_cmd_code <= c;
      io_eff_addr <= ea;
      io_r_field <= r;
      io_gen_reg0 <= g0;
      for (n = 0; n < 12 && resp[15] !== 1'b1; n++) begin
         @(posedge sys_clk);
         resp[15] = io_resp_valid;
      end
      resp[14:0] = {cond_code_bit_one, cond_code_bit_two, io_status_count, io_ret_addr};
      io_cmd_strobe <= 1'b0;
      for (n = 0; n < 10 && io_resp_valid !== 1'b0; n++)
         @(posedge sys_clk);
      io_eff_addr <= ~ea;
      io_gen_reg0 <= ~g0;
   endtask : io
endmodule : dio_cpu_model
`default_nettype wire

/* File: dv/tb_dio_responder.sv */
// self-checking bench for the direct and i/o command responder
`timescale 1ns/1ps
`default_nettype none
module tb_dio_responder;
   logic        sys_clk = 1'b0;
   logic        srst, clk_en, sw_wr, sw_rd, ok;
   logic        function_strobe_line, function_strobe_ack, return_code_line_a, return_code_line_b;
   logic        direct_exchange_exit, io_cmd_strobe, io_resp_valid, cond_code_bit_one, cond_code_bit_two;
   logic [1:0]  io_status_count, codes;
   logic [2:0]  io_cmd_code;
   logic [3:0]  direct_mode, io_r_field;
   logic [4:0]  sw_addr;
   logic [10:0] io_ret_addr, exp_addr;
   logic [15:0] direct_addr, resp;
   logic [31:0] direct_data, io_eff_addr, io_gen_reg0, sw_wdata, sw_rdata, rd;
   int          bad_count = 0, cmp_count = 0, cyc = 0;
   logic [4:0]  offs [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18, 5'h1C};
   logic [3:0]  mode_tab [5] = '{4'h3, 4'hF, 4'hF, 4'h0, 4'h1};
   // code, hit, r field, control, cc, count
   logic [23:0] io_tab [22] = '{24'h010000, 24'h013004, 24'h310024, 24'h310000, 24'h30000C, 24'h10000C,
      24'h110048, 24'h110084, 24'h110000, 24'h210048, 24'h210104, 24'h20000C, 24'h012002, 24'h310000,
      24'h011001, 24'h010048, 24'h41000C, 24'h410208, 24'h41000C, 24'h310200, 24'h41000C, 24'h51000C};

   dio_responder i_dio_responder (.*);
   dio_cpu_model i_dio_cpu_model (.*);

   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic sw_write(input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge sys_clk);
      sw_wr <= 1'b0;
   endtask : sw_write

   task automatic sw_read(input logic [4:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge sys_clk);
      sw_rd <= 1'b0;
      @(posedge sys_clk);
      d = sw_rdata;
   endtask : sw_read

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   initial begin
      {srst, clk_en} = 2'b11;
      {sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      sw_write(5'h1C, 32'hFFFFFFFF);
      foreach (offs[i]) begin
         sw_read(offs[i], rd);
         check(rd, 32'h0);
      end
      $display("test reset values done");
      sw_write(dio_pkg::DIO_REG_IOADDR, 32'hFFFFFAA5);
      // frozen clock enable must drop this write
      clk_en <= 1'b0;
      sw_write(dio_pkg::DIO_REG_IOADDR, 32'h00000123);
      clk_en <= 1'b1;
      sw_write(dio_pkg::DIO_REG_DADDR, 32'h1234BEEF);
      sw_write(dio_pkg::DIO_REG_CODES, 32'h00000009);
      sw_write(dio_pkg::DIO_REG_STATUS, 32'hFFFFFFFF);
      sw_read(dio_pkg::DIO_REG_IOADDR, rd);
      check(rd, 32'h2A5);
      sw_read(dio_pkg::DIO_REG_STATUS, rd);
      check(rd, 32'h0);
      foreach (mode_tab[i]) begin
         i_dio_cpu_model.wd(i == 2 ? 16'h1234 : 16'hBEEF, 32'hA5000000 + 32'(i), mode_tab[i], ok, codes);
         check(ok, i < 2);
         if (i < 2) check(codes, 2'b01);
      end
      sw_read(dio_pkg::DIO_REG_WDATA, rd);
      check(rd, 32'hA5000001);
      $display("test direct modes done");
      sw_write(dio_pkg::DIO_REG_CTRL, 32'h1);
      fork
         i_dio_cpu_model.wd(16'hBEEF, 32'h5A5A0000, 4'h7, ok, codes);
         begin
            repeat (16) @(posedge sys_clk);
            check(function_strobe_ack, 1'b1);
            check(direct_exchange_exit, 1'b0);
            sw_read(dio_pkg::DIO_REG_STATUS, rd);
            check(rd, 32'hC);
            sw_write(dio_pkg::DIO_REG_CTRL, 32'h41);
         end
      join
      check(ok, 1'b1);
      sw_write(dio_pkg::DIO_REG_CTRL, 32'h0);
      $display("test held exchange done");
      foreach (io_tab[i]) begin
         sw_write(dio_pkg::DIO_REG_CTRL, {24'h0, io_tab[i][11:4]});
         i_dio_cpu_model.io(1'b0, io_tab[i][22:20], io_tab[i][16] ? 32'hFFFFFAA5 : 32'h0000015A,
                            io_tab[i][15:12], {24'hC0DE00, 8'(i)}, resp);
         exp_addr = io_tab[i][22:20] == 3'h4 ? (io_tab[i][3:2] == 2'b11 ? 11'h000 : 11'h2A5)
                                             : (io_tab[i][16] ? 11'h2A5 : 11'h15A);
         check(resp[15:13], {1'b1, io_tab[i][3:2]});
         if (io_tab[i][3:2] == 2'b00 && io_tab[i][22:20] == 3'h0) check(resp[12:11], io_tab[i][1:0]);
         check(resp[10:0], exp_addr);
      end
      i_dio_cpu_model.io(1'b1, 3'h0, 32'hFFFFFAA5, 4'h0, 32'h0BAD0BAD, resp);
      check(resp[15], 1'b0);
      sw_read(dio_pkg::DIO_REG_CDW, rd);
      check(rd, 32'hC0DE000E);
      $display("test i/o commands done");
      finish_test();
   end
endmodule : tb_dio_responder
`default_nettype wire
